// ===== design/pcts_top.sv
// Card strobe timing register and SDRAM mode setting path
`timescale 1ns/1ps
// Behaviour
// - Timing register: 16 bits, power-on clears only
// - Register places strobes; base waits set width
// - Low-speed extra waits 0/15/30/50 per area
// - Fields apply only when access-type bit is 0
// - Address-to-strobe setup waits, eight-step code
// - Address hold after strobe, same eight steps
// - Write-only virtual mode registers, areas 2, 3
// - Write address offset is mode; data ignored
// - 32-bit bus delivers offset shifted right two
// - Bases fixed; offset range 0 to 0ffc
// - Mode register takes low 16 address bits
// - Burst 4 or 8 only; byte writes only
module pcts_top
  import pcts_pkg::*;
#(
  parameter bit BURST8_SUPPORTED = 1'b1
)
(
  // Clock, power-on reset and freeze
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  // Internal register access port
  input wire logic [31:0] BUS_ADDR,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  input wire logic [1:0] BUS_SIZE,
  input wire logic [15:0] BUS_WDATA,
  output logic [15:0] BUS_RDATA,
  output logic BUS_ACK,
  // Settings held elsewhere in the bus controller
  input wire logic ACCESS_TYPE_SELECT,
  input wire logic [3:0] BASE_WAIT_CONTROL,
  input wire logic SDRAM_BUS_32,
  // Card cycle request
  input wire logic PC_START,
  input wire logic PC_AREA6,
  input wire logic PC_WRITE,
  input wire logic PC_LOW_SPEED,
  // Card cycle strobes
  output logic PC_ADDR_EN,
  output logic PC_OE_N,
  output logic PC_WE_N,
  output logic PC_SAMPLE,
  output logic PC_DONE,
  output logic PC_BUSY,
  // SDRAM mode-set command
  output logic SD_MRS_REQ,
  output logic SD_MRS_AREA3,
  output logic [15:0] SD_MRS_VALUE,
  input wire logic SD_MRS_ACK
);

  // Eight-step setup and hold decoding, shared by both areas
  function automatic logic [3:0] step_waits(input logic [2:0] code);
    logic [3:0] w;
    w = {1'b0, code};
    case (code)
      3'h4: w = STEP_WAITS_4;
      3'h5: w = STEP_WAITS_5;
      3'h6: w = STEP_WAITS_6;
      3'h7: w = STEP_WAITS_7;
      default: w = {1'b0, code};
    endcase
    return w;
  endfunction : step_waits

  // Extra low-speed waits per two-bit code
  function automatic logic [6:0] extra_waits(input logic [1:0] code);
    logic [6:0] w;
    w = 7'h00;
    case (code)
      2'h1: w = EXTRA_WAITS_1;
      2'h2: w = EXTRA_WAITS_2;
      2'h3: w = EXTRA_WAITS_3;
      default: w = 7'h00;
    endcase
    return w;
  endfunction : extra_waits

  // Mode window hit test for one area base
  function automatic logic mode_hit(input logic [31:0] addr,
                                    input logic [31:0] base);
    return (addr[31:16] == base[31:16]) &&
           (addr[15:0] <= MODE_OFFSET_MAX);
  endfunction : mode_hit

  logic [15:0] card_strobe_timing_reg; // Software timing settings
  logic ack_reg; // One-cycle answer to a taken access
  logic [15:0] rdata_reg; // Read data for the answer
  logic mrs_req_reg; // Mode-set command pending
  logic mrs_area3_reg; // Target area of the pending command
  logic [15:0] mrs_value_reg; // Value for the SDRAM address lines

  logic [15:0] mode_next; // Value that reaches the SDRAM
  logic hit_timing; // Access addresses the timing register
  logic hit_a2; // Access falls in the area 2 mode window
  logic hit_a3; // Access falls in the area 3 mode window
  logic mode_stall; // Mode write waits for the previous command
  logic take_rd; // Read taken this cycle
  logic take_wr; // Write taken this cycle
  logic burst_ok; // Burst code is one the part supports
  logic [1:0] extra_code; // Selected area's extra wait code
  logic [2:0] setup_code; // Selected area's setup code
  logic [2:0] hold_code; // Selected area's hold code
  logic [3:0] seq_setup; // Setup waits for the sequencer
  logic [6:0] seq_strobe; // Strobe waits for the sequencer
  logic [3:0] seq_hold; // Hold waits for the sequencer

  // Address decode and request qualification
  always_comb begin
    hit_timing = 1'b0;
    hit_a2 = 1'b0;
    hit_a3 = 1'b0;
    if (BUS_ADDR == CARD_TIMING_ADDR) begin
      hit_timing = 1'b1;
    end else if (mode_hit(BUS_ADDR, MODE_BASE_AREA2)) begin
      hit_a2 = 1'b1;
    end else if (mode_hit(BUS_ADDR, MODE_BASE_AREA3)) begin
      hit_a3 = 1'b1;
    end
    // A second mode write waits so no command is lost
    mode_stall = BUS_WR && (hit_a2 || hit_a3) && mrs_req_reg;
    take_rd = BUS_RD && !BUS_WR && !ack_reg;
    take_wr = BUS_WR && !ack_reg && !mode_stall;
  end

  // Value delivered to the SDRAM and its burst check
  always_comb begin
    mode_next = BUS_ADDR[15:0];
    if (SDRAM_BUS_32) begin
      mode_next = BUS_ADDR[15:0] >> MODE_SHIFT;
    end
    burst_ok = (mode_next[2:0] == BURST_LEN_4) ||
               (BURST8_SUPPORTED && (mode_next[2:0] == BURST_LEN_8));
  end

  // Timing register: only the power-on reset clears it
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      card_strobe_timing_reg <= CARD_TIMING_RESET;
    end else if (CLK_EN) begin
      // Byte writes are not merged; software uses word access here
      if (take_wr && hit_timing && (BUS_SIZE != SIZE_BYTE)) begin
        card_strobe_timing_reg <= BUS_WDATA;
      end
    end
  end

  // Register port answer; the port is quiet for one cycle after it
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else if (CLK_EN) begin
      ack_reg <= take_rd || take_wr;
      if (take_rd) begin
        // Mode windows are write only and read back as zero
        if (hit_timing) begin
          rdata_reg <= card_strobe_timing_reg;
        end else begin
          rdata_reg <= 16'h0000;
        end
      end
    end
  end

  // Mode-set command: address carries the value, data is dropped
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mrs_req_reg <= 1'b0;
      mrs_area3_reg <= 1'b0;
      mrs_value_reg <= 16'h0000;
    end else if (CLK_EN) begin
      if (take_wr && (hit_a2 || hit_a3) && (BUS_SIZE == SIZE_BYTE) &&
          burst_ok) begin
        mrs_req_reg <= 1'b1;
        mrs_area3_reg <= hit_a3;
        mrs_value_reg <= mode_next;
      end else if (SD_MRS_ACK) begin
        mrs_req_reg <= 1'b0;
      end
    end
  end

  // Field selection for the addressed area; access-type bit gates all
  always_comb begin
    if (PC_AREA6) begin
      extra_code = card_strobe_timing_reg[A6_EXTRA_LSB +: 2];
      setup_code = card_strobe_timing_reg[A6_SETUP_LSB +: 3];
      hold_code = card_strobe_timing_reg[A6_HOLD_LSB +: 3];
    end else begin
      extra_code = card_strobe_timing_reg[A5_EXTRA_LSB +: 2];
      setup_code = card_strobe_timing_reg[A5_SETUP_LSB +: 3];
      hold_code = card_strobe_timing_reg[A5_HOLD_LSB +: 3];
    end
    seq_setup = 4'h0;
    seq_hold = 4'h0;
    seq_strobe = {3'h0, BASE_WAIT_CONTROL};
    if (!ACCESS_TYPE_SELECT) begin
      seq_setup = step_waits(setup_code);
      seq_hold = step_waits(hold_code);
      if (PC_LOW_SPEED) begin
        seq_strobe = {3'h0, BASE_WAIT_CONTROL} + extra_waits(extra_code);
      end
    end
  end

  // Timing is latched at cycle start, so a write mid-cycle waits
  pcts_card_seq u_seq (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CLK_EN),
    .start(PC_START),
    .write(PC_WRITE),
    .setup_waits(seq_setup),
    .strobe_waits(seq_strobe),
    .hold_waits(seq_hold),
    .addr_en(PC_ADDR_EN),
    .oe_n(PC_OE_N),
    .we_n(PC_WE_N),
    .sample(PC_SAMPLE),
    .done(PC_DONE),
    .busy(PC_BUSY)
  );

  // Port drive
  always_comb begin
    BUS_ACK = ack_reg;
    BUS_RDATA = rdata_reg;
    SD_MRS_REQ = mrs_req_reg;
    SD_MRS_AREA3 = mrs_area3_reg;
    SD_MRS_VALUE = mrs_value_reg;
  end

endmodule : pcts_top

// ===== include/pcts_pkg.sv
// Constants shared by the card timing and SDRAM mode setting logic
package pcts_pkg;

  // Register addresses
  localparam logic [31:0] CARD_TIMING_ADDR = 32'hff80_001c;
  localparam logic [31:0] MODE_BASE_AREA2 = 32'hff90_0000;
  localparam logic [31:0] MODE_BASE_AREA3 = 32'hff94_0000;
  localparam logic [15:0] MODE_OFFSET_MAX = 16'h0ffc;
  localparam logic [15:0] CARD_TIMING_RESET = 16'h0000;

  // Field positions inside the card timing register
  localparam int A5_EXTRA_LSB = 14;
  localparam int A6_EXTRA_LSB = 12;
  localparam int A5_SETUP_LSB = 9;
  localparam int A6_SETUP_LSB = 6;
  localparam int A5_HOLD_LSB = 3;
  localparam int A6_HOLD_LSB = 0;

  // Extra low-speed wait counts per two-bit code
  localparam logic [6:0] EXTRA_WAITS_1 = 7'h0f;
  localparam logic [6:0] EXTRA_WAITS_2 = 7'h1e;
  localparam logic [6:0] EXTRA_WAITS_3 = 7'h32;

  // Setup and hold wait counts for the upper four three-bit codes
  localparam logic [3:0] STEP_WAITS_4 = 4'h6;
  localparam logic [3:0] STEP_WAITS_5 = 4'h9;
  localparam logic [3:0] STEP_WAITS_6 = 4'hc;
  localparam logic [3:0] STEP_WAITS_7 = 4'hf;

  // Access size codes on the register port
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;

  // SDRAM mode value handling
  localparam int MODE_SHIFT = 2;
  localparam logic [2:0] BURST_LEN_4 = 3'h2;
  localparam logic [2:0] BURST_LEN_8 = 3'h3;

  // Card cycle sequencer states
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h1,
    SEQ_SETUP = 4'h2,
    SEQ_STROBE = 4'h4,
    SEQ_HOLD = 4'h8
  } pcts_seq_state_t;

endpackage : pcts_pkg

// ===== design/pcts_card_seq.sv
// Card bus cycle sequencer: address setup, strobe, address hold
`timescale 1ns/1ps
module pcts_card_seq
  import pcts_pkg::*;
(
  // Clock, reset and freeze
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Cycle request with latched timing
  input wire logic start,
  input wire logic write,
  input wire logic [3:0] setup_waits,
  input wire logic [6:0] strobe_waits,
  input wire logic [3:0] hold_waits,
  // Card side strobes
  output logic addr_en,
  output logic oe_n,
  output logic we_n,
  output logic sample,
  output logic done,
  output logic busy
);

  pcts_seq_state_t state_reg; // Current phase
  logic [6:0] count_reg; // Cycles left in the phase
  logic write_reg; // Direction of the running cycle
  logic [3:0] hold_reg; // Hold count kept for the hold phase
  // Strobe length is latched too, so a register write mid-cycle waits
  logic [6:0] strobe_reg; // Strobe count kept for the strobe phase

  // Phase sequencing; setup and hold counts of zero skip their phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SEQ_IDLE;
      count_reg <= 7'h00;
      write_reg <= 1'b0;
      hold_reg <= 4'h0;
      strobe_reg <= 7'h00;
    end else if (ce) begin
      case (state_reg)
        SEQ_IDLE: begin
          if (start) begin
            write_reg <= write;
            hold_reg <= hold_waits;
            strobe_reg <= strobe_waits;
            if (setup_waits != 4'h0) begin
              state_reg <= SEQ_SETUP;
              count_reg <= {3'h0, setup_waits} - 7'h01;
            end else begin
              state_reg <= SEQ_STROBE;
              count_reg <= strobe_waits;
            end
          end
        end
        SEQ_SETUP: begin
          if (count_reg == 7'h00) begin
            state_reg <= SEQ_STROBE;
            count_reg <= strobe_reg;
          end else begin
            count_reg <= count_reg - 7'h01;
          end
        end
        SEQ_STROBE: begin
          if (count_reg == 7'h00) begin
            if (hold_reg != 4'h0) begin
              state_reg <= SEQ_HOLD;
              count_reg <= {3'h0, hold_reg} - 7'h01;
            end else begin
              state_reg <= SEQ_IDLE;
            end
          end else begin
            count_reg <= count_reg - 7'h01;
          end
        end
        SEQ_HOLD: begin
          // Hold counts from the cycle after sampling or negation
          if (count_reg == 7'h00) begin
            state_reg <= SEQ_IDLE;
          end else begin
            count_reg <= count_reg - 7'h01;
          end
        end
        default: begin
          state_reg <= SEQ_IDLE;
        end
      endcase
    end
  end

  // Strobe outputs are decoded from registered state; done is also gated by ce
  always_comb begin
    addr_en = (state_reg != SEQ_IDLE);
    oe_n = !((state_reg == SEQ_STROBE) && !write_reg);
    we_n = !((state_reg == SEQ_STROBE) && write_reg);
    sample = (state_reg == SEQ_STROBE) && (count_reg == 7'h00);
    busy = (state_reg != SEQ_IDLE);
    done = ce && (((state_reg == SEQ_STROBE) && (count_reg == 7'h00) &&
           (hold_reg == 4'h0)) ||
           ((state_reg == SEQ_HOLD) && (count_reg == 7'h00)));
  end

endmodule : pcts_card_seq

// ===== verification/pcts_top_props.sv
// Port checker for the card timing and SDRAM mode path
`timescale 1ns/1ps
module pcts_top_props
  import pcts_pkg::*;
#(
  parameter bit BURST8_SUPPORTED = 1'b1
)
(
  // Clock, reset and freeze
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  // Register port and settings
  input wire logic [31:0] BUS_ADDR,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  input wire logic [1:0] BUS_SIZE,
  input wire logic BUS_ACK,
  input wire logic SDRAM_BUS_32,
  input wire logic ACCESS_TYPE_SELECT,
  // Card strobes
  input wire logic PC_ADDR_EN,
  input wire logic PC_OE_N,
  input wire logic PC_WE_N,
  input wire logic PC_SAMPLE,
  input wire logic PC_DONE,
  input wire logic PC_BUSY,
  // Mode-set command
  input wire logic SD_MRS_REQ,
  input wire logic SD_MRS_AREA3,
  input wire logic [15:0] SD_MRS_VALUE,
  input wire logic SD_MRS_ACK
);
  // One clock domain, so both defaults are set once
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic strobe_on; // Either card strobe asserted
  logic [15:0] mode_exp; // Address lines a write would produce
  assign strobe_on = !(PC_OE_N && PC_WE_N);
  assign mode_exp = SDRAM_BUS_32 ? {2'h0, BUS_ADDR[15:2]} : BUS_ADDR[15:0];

  read_ack_a: assert property (CLK_EN && BUS_RD && !BUS_WR
    && !BUS_ACK |=> BUS_ACK) else $error("read not acknowledged");
  mrs_ack_a: assert property ($rose(SD_MRS_REQ) |-> BUS_ACK)
    else $error("mode command without bus ack");
  mrs_value_a: assert property ($rose(SD_MRS_REQ) |->
    SD_MRS_VALUE == $past(mode_exp))
    else $error("mode value not from address");
  mrs_area_a: assert property ($rose(SD_MRS_REQ) |->
    SD_MRS_AREA3 == $past(BUS_ADDR[18]))
    else $error("mode command to wrong area");
  mrs_legal_a: assert property ($rose(SD_MRS_REQ) |->
    $past(BUS_SIZE) == SIZE_BYTE && $past(BUS_ADDR[15:0]) <= MODE_OFFSET_MAX)
    else $error("illegal mode write accepted");
  burst_code_a: assert property (SD_MRS_REQ |->
    SD_MRS_VALUE[2:0] == BURST_LEN_4 ||
    (BURST8_SUPPORTED && SD_MRS_VALUE[2:0] == BURST_LEN_8))
    else $error("unsupported burst length sent");
  mrs_hold_a: assert property (SD_MRS_REQ && !SD_MRS_ACK |=>
    SD_MRS_REQ && $stable(SD_MRS_VALUE))
    else $error("mode command dropped early");
  strobe_gate_a: assert property (strobe_on |-> PC_ADDR_EN &&
    (PC_OE_N || PC_WE_N)) else $error("strobe outside address");
  sample_end_a: assert property (PC_SAMPLE |->
    strobe_on ##1 !strobe_on) else $error("strobe not negated after sample");
  done_end_a: assert property (PC_DONE |-> PC_BUSY ##1 !PC_BUSY)
    else $error("card cycle not ended after done");
  bypass_a: assert property ($rose(PC_BUSY) &&
    $past(ACCESS_TYPE_SELECT) |-> strobe_on)
    else $error("setup waits while bypassed");

  // Main scenarios reached
  cover property ($rose(SD_MRS_REQ));
  cover property (SD_MRS_REQ && BUS_WR && !BUS_ACK);
  cover property (PC_DONE && !strobe_on);
endmodule : pcts_top_props

bind pcts_top pcts_top_props #(.BURST8_SUPPORTED(BURST8_SUPPORTED))
  u_props (.*);

// ===== verification/pcts_sdram_model.sv
// Behavioural SDRAM sequencer answering mode-set commands
`timescale 1ns/1ps
module pcts_sdram_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Mode-set command and chosen answer delay
  input wire logic mrs_req,
  input wire logic mrs_area3,
  input wire logic [15:0] mrs_value,
  input wire logic [1:0] delay,
  output logic mrs_ack,
  // Last command taken, for the bench
  output logic [15:0] got_value,
  output logic got_area3,
  output int got_count
);
  logic [1:0] wait_reg; // Cycles spent before answering
  // A delay lets slow devices stall the controller too
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mrs_ack <= 1'b0;
      wait_reg <= 2'h0;
      got_count <= 0;
    end else if (mrs_ack) begin
      mrs_ack <= 1'b0;
    end else if (mrs_req && wait_reg == delay) begin
      mrs_ack <= 1'b1;
      wait_reg <= 2'h0;
      got_value <= mrs_value;
      got_area3 <= mrs_area3;
      got_count <= got_count + 1;
    end else if (mrs_req) begin
      wait_reg <= wait_reg + 2'h1;
    end
  end
endmodule : pcts_sdram_model

// ===== verification/pcts_top_test.sv
// Self-checking bench for the card timing and SDRAM mode path
`timescale 1ns/1ps
module pcts_top_test;
  import pcts_pkg::*;
  // Stimulus and observed values
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ats = 1'b0;
  logic bus32 = 1'b1, start = 1'b0, area6 = 1'b0, pwr = 1'b0, slow = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [1:0] size = 2'h0, dly = 2'h0;
  logic [15:0] wdata = 16'h0, rq, rdata, mval, gval;
  logic [3:0] base = 4'h0;
  logic ack, aen, oe_n, we_n, smp, done, busy, mreq, marea, mack, garea;
  int gcnt, mismatches = 0, n_tests = 0;

  always #4 clk = ~clk;

  pcts_top dut (.CLK(clk), .RST_N(rst_n), .CLK_EN(1'b1), .BUS_ADDR(addr),
    .BUS_WR(wr), .BUS_RD(rd), .BUS_SIZE(size), .BUS_WDATA(wdata),
    .BUS_RDATA(rdata), .BUS_ACK(ack), .ACCESS_TYPE_SELECT(ats),
    .BASE_WAIT_CONTROL(base), .SDRAM_BUS_32(bus32), .PC_START(start),
    .PC_AREA6(area6), .PC_WRITE(pwr), .PC_LOW_SPEED(slow),
    .PC_ADDR_EN(aen), .PC_OE_N(oe_n), .PC_WE_N(we_n), .PC_SAMPLE(smp),
    .PC_DONE(done), .PC_BUSY(busy), .SD_MRS_REQ(mreq),
    .SD_MRS_AREA3(marea), .SD_MRS_VALUE(mval), .SD_MRS_ACK(mack));
  pcts_sdram_model sdram (.clk(clk), .rst_n(rst_n), .mrs_req(mreq),
    .mrs_area3(marea), .mrs_value(mval), .delay(dly), .mrs_ack(mack),
    .got_value(gval), .got_area3(garea), .got_count(gcnt));

  // Waits for a three-bit setup or hold code
  function automatic int step(input logic [2:0] c);
    return c < 3'h4 ? int'(c) : 3 * int'(c) - 6;
  endfunction : step
  // Extra low-speed waits for a two-bit code
  function automatic int extra(input logic [1:0] c);
    return c == 2'h0 ? 0 : c == 2'h1 ? 15 : c == 2'h2 ? 30 : 50;
  endfunction : extra

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  // A wait that ran out ends the run
  task automatic hang(input string what);
    check(what, 16'h0, 16'h1);
    finish_test();
  endtask : hang

  // Register access held until the one-cycle ack
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [1:0] s, input logic [15:0] d);
    @(posedge clk);
    #1;
    wr = w;
    rd = !w;
    addr = a;
    size = s;
    wdata = d;
    for (int n = 0; n < 100 && ack !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (ack !== 1'b1) hang("bus ack");
    rq = rdata;
    // Request stands through the edge that samples the answer
    @(posedge clk);
    #1;
    wr = 1'b0;
    rd = 1'b0;
  endtask : bus

  // Let a pending mode command be answered
  task automatic settle;
    for (int n = 0; n < 50 && mreq !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    if (mreq !== 1'b0) hang("mode request");
  endtask : settle

  task automatic mode(input logic [31:0] a, input logic [1:0] s,
                      input logic ok);
    int c0;
    c0 = gcnt;
    bus(1'b1, a, s, 16'($urandom));
    settle();
    check("mode count", 16'(c0 + int'(ok)), 16'(gcnt));
    if (ok) begin
      check("mode value", bus32 ? {2'h0, a[15:2]} : a[15:0], gval);
      check("mode area", {15'h0, a[18]}, {15'h0, garea});
    end
  endtask : mode

  // One card cycle, phase lengths compared with the fields
  task automatic card(input logic [15:0] t, input logic a6);
    int s, w, h, su, st, tot, na, ns, sp;
    na = 0;
    ns = 0;
    sp = 0;
    bus(1'b1, CARD_TIMING_ADDR, SIZE_WORD, t);
    area6 = a6;
    pwr = 1'($urandom);
    slow = 1'($urandom);
    base = 4'($urandom);
    ats = ($urandom_range(0, 3) == 0);
    s = ats ? 0 : step(a6 ? t[8:6] : t[11:9]);
    h = ats ? 0 : step(a6 ? t[2:0] : t[5:3]);
    w = base + ((ats || !slow) ? 0 : extra(a6 ? t[13:12] : t[15:14]));
    start = 1'b1;
    @(posedge clk);
    #1;
    start = 1'b0;
    su = 0;
    st = 0;
    for (tot = 1; tot < 300; tot++) begin
      if (!(pwr ? we_n : oe_n)) st++;
      else if (st == 0) su++;
      if (aen === 1'b1) na++;
      if (smp === 1'b1) begin
        ns++;
        sp = st;
      end
      // Rewrite the timing mid-cycle; the running cycle keeps its copy
      if (tot == 1 && s + w + h > 1) begin
        wr = 1'b1;
        addr = CARD_TIMING_ADDR;
        size = SIZE_WORD;
        wdata = ~t;
      end
      if (tot == 3) wr = 1'b0;
      if (done === 1'b1) break;
      @(posedge clk);
      #1;
    end
    if (done !== 1'b1) hang("card done");
    check("setup cycles", 16'(s), 16'(su));
    check("strobe cycles", 16'(w + 1), 16'(st));
    check("total cycles", 16'(s + w + 1 + h), 16'(tot));
    check("address cycles", 16'(tot), 16'(na));
    check("sample pulses", 16'h1, 16'(ns));
    check("sample point", 16'(w + 1), 16'(sp));
  endtask : card

  initial begin
    logic [15:0] v;
    logic [15:0] t;
    void'($urandom(4));
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    bus(1'b0, CARD_TIMING_ADDR, SIZE_WORD, 16'h0);
    check("timing reset", CARD_TIMING_RESET, rq);
    v = 16'($urandom);
    bus(1'b1, CARD_TIMING_ADDR, SIZE_LONG, v);
    bus(1'b1, CARD_TIMING_ADDR, SIZE_BYTE, ~v);
    bus(1'b0, CARD_TIMING_ADDR, SIZE_WORD, 16'h0);
    check("timing value", v, rq);
    bus(1'b0, CARD_TIMING_ADDR + 32'h4, SIZE_WORD, 16'h0);
    check("unmapped read", 16'h0, rq);
    bus(1'b0, MODE_BASE_AREA2 + 32'h48, SIZE_WORD, 16'h0);
    check("mode read", 16'h0, rq);
    // Mode set first, as SDRAM use must follow it
    for (int i = 0; i < 18; i++) begin
      dly = 2'($urandom_range(0, 3));
      v = i < 12 ? 16'(64 * (i % 3 + 1) + 8 + 4 * ((i / 3) % 2))
                 : {4'h0, 7'($urandom), 5'h08};
      mode((i[0] ? MODE_BASE_AREA3 : MODE_BASE_AREA2) + {16'h0, v},
           SIZE_BYTE, 1'b1);
    end
    mode(MODE_BASE_AREA2 + 32'h48, SIZE_WORD, 1'b0);
    mode(MODE_BASE_AREA3 + 32'h1048, SIZE_BYTE, 1'b0);
    mode(MODE_BASE_AREA2 + 32'h40, SIZE_BYTE, 1'b0);
    bus32 = 1'b0;
    mode(MODE_BASE_AREA3 + 32'h22, SIZE_BYTE, 1'b1);
    mode(MODE_BASE_AREA3 + 32'h48, SIZE_BYTE, 1'b0);
    bus32 = 1'b1;
    dly = 2'h3;
    t = 16'(gcnt);
    bus(1'b1, MODE_BASE_AREA2 + 32'h88, SIZE_BYTE, 16'h0);
    bus(1'b1, MODE_BASE_AREA3 + 32'hc8, SIZE_BYTE, 16'h0);
    settle();
    check("stalled count", t + 16'h2, 16'(gcnt));
    check("stalled value", 16'h0032, gval);
    for (int i = 0; i < 24; i++) begin
      t = {i[1:0], i[1:0], i[2:0], i[2:0], i[2:0], i[2:0]};
      card(i < 16 ? t : 16'($urandom), i[3]);
    end
    finish_test();
  end
endmodule : pcts_top_test
